//--- core/rss_alu.sv
`timescale 1ns/1ps
// ==========================================================================
// Combinational operation unit
// ==========================================================================
module rss_alu import rss_pkg::*; (
  // Operation
  input wire logic [4:0] op,
  input wire logic [2:0] bit_sel,
  // Operands
  input wire logic [7:0] work,
  input wire logic [7:0] mem,
  input wire logic [7:0] imm,
  input wire logic [15:0] table_word,
  input wire rss_flags_t flags_in,
  // Outcome
  output rss_alu_out_t res
);

  logic [7:0] sub_b;
  logic borrow;
  logic [8:0] diff;
  logic [4:0] nib;
  logic [7:0] dec_v;
  logic [7:0] inc_v;
  logic [7:0] xor_v;
  rss_flags_t sub_fl;

  // Subtract path shared by all subtract forms
  assign sub_b = (op == OP_SUBTRACT_IMM) ? imm : mem; // RULE6
  assign borrow = (op == OP_MINUS_BORROW_WORK || op == OP_MINUS_BORROW_MEM)
                  ? ~flags_in.c : 1'b0; // RULE4
  assign diff = {1'b0, work} - {1'b0, sub_b} - {8'h00, borrow};
  assign nib = {1'b0, work[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, borrow};
  assign sub_fl.ov = (work[7] ^ sub_b[7]) & (work[7] ^ diff[7]);
  assign sub_fl.z = (diff[7:0] == ZERO_BYTE); // RULE19
  assign sub_fl.ac = ~nib[4];
  assign sub_fl.c = ~diff[8]; // RULE5
  assign dec_v = mem - ONE_BYTE;
  assign inc_v = mem + ONE_BYTE;
  assign xor_v = work ^ mem;

  // Per-operation result, destination and skip
  always_comb begin
    res = '0;
    res.flags = flags_in;
    res.result = mem;
    unique case (op)
      OP_ROTL_CARRY_TO_WORK: begin
        res.result = {mem[6:0], flags_in.c}; // RULE1
        res.flags.c = mem[7]; // RULE1
        res.wr_work = 1'b1;
      end
      OP_ROTR_MEM, OP_ROTR_TO_WORK: begin
        res.result = {mem[0], mem[7:1]}; // RULE2
        res.wr_mem = (op == OP_ROTR_MEM);
        res.wr_work = (op == OP_ROTR_TO_WORK);
      end
      OP_ROTR_THRU_CARRY_MEM, OP_ROTR_THRU_CARRY_TO_WORK: begin
        res.result = {flags_in.c, mem[7:1]}; // RULE3
        res.flags.c = mem[0]; // RULE3
        res.wr_mem = (op == OP_ROTR_THRU_CARRY_MEM);
        res.wr_work = (op == OP_ROTR_THRU_CARRY_TO_WORK);
      end
      OP_MINUS_BORROW_WORK, OP_SUBTRACT_WORK, OP_SUBTRACT_IMM: begin
        res.result = diff[7:0]; // RULE4 RULE6
        res.flags = sub_fl; // RULE5
        res.wr_work = 1'b1;
      end
      OP_MINUS_BORROW_MEM, OP_SUBTRACT_TO_MEM: begin
        res.result = diff[7:0]; // RULE4 RULE6
        res.flags = sub_fl; // RULE5
        res.wr_mem = 1'b1;
      end
      OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_WORK: begin
        res.result = dec_v; // RULE7
        res.skip = (dec_v == ZERO_BYTE); // RULE7
        res.wr_mem = (op == OP_DEC_SKIP_ZERO);
        res.wr_work = (op == OP_DEC_SKIP_ZERO_WORK);
      end
      OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_WORK: begin
        res.result = inc_v; // RULE8
        res.skip = (inc_v == ZERO_BYTE); // RULE8
        res.wr_mem = (op == OP_INC_SKIP_ZERO);
        res.wr_work = (op == OP_INC_SKIP_ZERO_WORK);
      end
      OP_SET_BYTE: begin
        res.result = ALL_ONES; // RULE10
        res.wr_mem = 1'b1;
      end
      OP_SET_BIT: begin
        res.result = mem | rss_bit_mask(bit_sel); // RULE10
        res.wr_mem = 1'b1;
      end
      OP_SKIP_BIT_SET: res.skip = |(mem & rss_bit_mask(bit_sel)); // RULE11
      OP_SKIP_BIT_CLEAR: res.skip = ~|(mem & rss_bit_mask(bit_sel)); // RULE14
      OP_SKIP_IF_ZERO: res.skip = (mem == ZERO_BYTE); // RULE12
      OP_COPY_SKIP_ZERO: begin
        res.wr_work = 1'b1; // RULE13
        res.skip = (mem == ZERO_BYTE); // RULE13
      end
      OP_NIBBLE_EXCHANGE_MEM, OP_NIBBLE_EXCHANGE_WORK: begin
        res.result = {mem[3:0], mem[7:4]}; // RULE15
        res.wr_mem = (op == OP_NIBBLE_EXCHANGE_MEM);
        res.wr_work = (op == OP_NIBBLE_EXCHANGE_WORK);
      end
      OP_TABLE_FETCH, OP_TABLE_FETCH_LAST_PAGE: begin
        res.result = table_word[7:0]; // RULE16 RULE17
        res.wr_mem = 1'b1;
        res.wr_latch = 1'b1;
      end
      OP_XOR_WORK: begin
        res.result = xor_v; // RULE18
        res.flags.z = (xor_v == ZERO_BYTE); // RULE18 RULE19
        res.wr_work = 1'b1;
      end
      // Unused codes execute as a no-op
      default: res.skip = 1'b0;
    endcase
  end

endmodule : rss_alu

//--- core/rss_exec.sv
`timescale 1ns/1ps
// ==========================================================================
// Rotate, subtract, skip and table execution unit with APB access
// ==========================================================================
// Functional notes
// RULE1: Rotate left through carry into work register; memory stays unchanged.
// RULE2: Plain rotate right wraps bit 0 into bit 7, no flag changes.
// RULE3: Rotate right through carry: carry into bit 7, bit 0 to carry.
// RULE4: Subtract with borrow: work less byte less inverted carry, four flags.
// RULE5: Subtract carry clears on negative result, sets on zero or positive.
// RULE6: Plain subtract of byte or immediate, no borrow, four flags updated.
// RULE7: Decrement byte, skip when zero; work variant leaves memory; no flags.
// RULE8: Increment byte, skip when zero; work variant leaves memory; no flags.
// RULE9: Every skip taken costs a second, dummy instruction cycle.
// RULE10: Byte set writes all ones; bit set forces one bit; no flags.
// RULE11: Skip when selected bit is one; flags untouched.
// RULE12: Skip when addressed byte is zero; nothing else changes.
// RULE13: Copy byte to work register, skip when it is zero.
// RULE14: Skip when selected bit is zero.
// RULE15: Swap byte nibbles into memory or work register; no flags.
// RULE16: Table fetch via pointer pair or low pointer; low byte, high latch.
// RULE17: Last-page table fetch uses low pointer only, same split.
// RULE18: Exclusive OR of work and byte into work, zero flag only.
// RULE19: Zero flag set when written result is zero, else cleared.
module rss_exec import rss_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Execution status
  output logic busy,
  output logic skip_taken
);

  // ========================================================================
  // State
  // ========================================================================
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_DUMMY = 3'b100
  } rss_state_t;

  typedef struct packed {
    rss_state_t st;
    rss_cmd_t cmd;
    logic [7:0] work;
    rss_flags_t flags;
    logic [7:0] tp_low;
    logic [7:0] tp_high;
    logic high_en;
    logic [7:0] latch;
    logic busy;
    logic skip_taken;
    logic [DM_DEPTH-1:0][7:0] dmem;
    logic [PM_DEPTH-1:0][15:0] pmem;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rss_regs_t;

  localparam rss_regs_t REGS_RST = '{st: ST_IDLE, default: '0};

  rss_regs_t r;
  rss_regs_t next_r;
  rss_alu_out_t alu_res;
  logic [15:0] table_word;
  logic setup;
  logic access;
  logic last_page;

  // ========================================================================
  // Address decode
  // ========================================================================
  function automatic logic is_dmem(input logic [7:0] a);
    is_dmem = ((a & DMEM_MASK) == OFF_DMEM);
  endfunction : is_dmem

  function automatic logic is_pmem(input logic [7:0] a);
    is_pmem = ((a & PMEM_MASK) == OFF_PMEM);
  endfunction : is_pmem

  // Unaligned and unlisted addresses are not mapped
  function automatic logic addr_ok(input logic [7:0] a);
    logic hit;
    hit = (a == OFF_CMD) || (a == OFF_WORK) || (a == OFF_FLAGS) ||
          (a == OFF_TPTR) || (a == OFF_TLATCH) || (a == OFF_STAT) ||
          is_dmem(a) || is_pmem(a);
    addr_ok = hit && (a[IDX_LSB-1:0] == '0);
  endfunction : addr_ok

  // Read data; reserved bits return zero
  function automatic logic [31:0] read_data(input logic [7:0] a,
                                            input rss_regs_t s);
    logic [31:0] d;
    d = '0;
    if (is_dmem(a)) begin
      d[7:0] = s.dmem[a[IDX_LSB +: DM_AW]];
    end else if (is_pmem(a)) begin
      d[15:0] = s.pmem[a[IDX_LSB +: PM_AW]];
    end else begin
      unique case (a)
        OFF_WORK: d[7:0] = s.work;
        OFF_FLAGS: d[3:0] = s.flags;
        OFF_TPTR: begin
          d[TP_LOW_LSB +: 8] = s.tp_low;
          d[TP_HIGH_LSB +: 8] = s.tp_high;
          d[TP_HEN_BIT] = s.high_en;
        end
        OFF_TLATCH: d[7:0] = s.latch;
        OFF_STAT: begin
          d[STAT_BUSY_BIT] = s.busy;
          d[STAT_SKIP_BIT] = s.skip_taken;
        end
        // Command register reads back the last command
        OFF_CMD: begin
          d[CMD_OP_LSB +: 5] = s.cmd.op;
          d[CMD_BIT_LSB +: 3] = s.cmd.bit_sel;
          d[CMD_MA_LSB +: DM_AW] = s.cmd.maddr;
          d[CMD_IMM_LSB +: 8] = s.cmd.imm;
        end
        default: d = '0;
      endcase
    end
    read_data = d;
  endfunction : read_data

  // ========================================================================
  // Datapath instances
  // ========================================================================
  assign last_page = (r.cmd.op == OP_TABLE_FETCH_LAST_PAGE); // RULE17

  rss_table_rd u_table (
    .pmem (r.pmem),
    .tp_low (r.tp_low),
    .tp_high (r.tp_high),
    .high_en (r.high_en),
    .last_page (last_page),
    .word (table_word)
  );

  rss_alu u_alu (
    .op (r.cmd.op),
    .bit_sel (r.cmd.bit_sel),
    .work (r.work),
    .mem (r.dmem[r.cmd.maddr]),
    .imm (r.cmd.imm),
    .table_word (table_word),
    .flags_in (r.flags),
    .res (alu_res)
  );

  // ========================================================================
  // APB phases
  // ========================================================================
  // Zero wait states: pready is raised for the first access cycle
  assign setup = psel & ~penable;
  assign access = psel & penable & r.pready;

  // ========================================================================
  // Next-state logic
  // ========================================================================
  always_comb begin
    next_r = r;

    // Answer is prepared in the setup cycle so every output is a flop
    if (setup) begin
      next_r.pready = 1'b1;
      next_r.prdata = read_data(paddr, r);
      // Writes while busy would race the datapath, so they are refused
      next_r.pslverr = ~addr_ok(paddr) | (pwrite & r.busy);
    end else begin
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
    end

    // Register writes take effect at the access edge only
    if (access && pwrite && !r.pslverr) begin
      if (is_dmem(paddr)) begin
        next_r.dmem[paddr[IDX_LSB +: DM_AW]] = pwdata[7:0];
      end else if (is_pmem(paddr)) begin
        next_r.pmem[paddr[IDX_LSB +: PM_AW]] = pwdata[15:0];
      end else begin
        unique case (paddr)
          OFF_CMD: begin
            next_r.cmd.op = pwdata[CMD_OP_LSB +: 5];
            next_r.cmd.bit_sel = pwdata[CMD_BIT_LSB +: 3];
            next_r.cmd.maddr = pwdata[CMD_MA_LSB +: DM_AW];
            next_r.cmd.imm = pwdata[CMD_IMM_LSB +: 8];
            next_r.st = ST_EXEC;
            next_r.busy = 1'b1;
            next_r.skip_taken = 1'b0;
          end
          OFF_WORK: next_r.work = pwdata[7:0];
          OFF_FLAGS: next_r.flags = pwdata[3:0];
          OFF_TPTR: begin
            next_r.tp_low = pwdata[TP_LOW_LSB +: 8];
            next_r.tp_high = pwdata[TP_HIGH_LSB +: 8];
            next_r.high_en = pwdata[TP_HEN_BIT];
          end
          // Latch and status are read-only; writes are dropped
          default: next_r.busy = r.busy;
        endcase
      end
    end

    // Instruction sequencing
    unique case (r.st)
      ST_IDLE: begin
        next_r.busy = next_r.busy;
      end
      ST_EXEC: begin
        if (alu_res.wr_mem) begin
          next_r.dmem[r.cmd.maddr] = alu_res.result;
        end
        if (alu_res.wr_work) begin
          next_r.work = alu_res.result;
        end
        if (alu_res.wr_latch) begin
          next_r.latch = table_word[15:8]; // RULE16 RULE17
        end
        next_r.flags = alu_res.flags;
        next_r.skip_taken = alu_res.skip;
        // A taken skip inserts the dummy cycle
        if (alu_res.skip) begin
          next_r.st = ST_DUMMY; // RULE9
        end else begin
          next_r.st = ST_IDLE;
          next_r.busy = 1'b0;
        end
      end
      ST_DUMMY: begin
        next_r.st = ST_IDLE; // RULE9
        next_r.busy = 1'b0;
      end
      // Recover from a corrupted state code
      default: begin
        next_r.st = ST_IDLE;
        next_r.busy = 1'b0;
      end
    endcase
  end

  // ========================================================================
  // State register
  // ========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= REGS_RST;
    end else begin
      r <= next_r;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign busy = r.busy;
  assign skip_taken = r.skip_taken;

endmodule : rss_exec

//--- core/rss_table_rd.sv
`timescale 1ns/1ps
// ==========================================================================
// Program word selection for table fetches
// ==========================================================================
module rss_table_rd import rss_pkg::*; (
  // Program store
  input wire logic [PM_DEPTH-1:0][15:0] pmem,
  // Pointer state
  input wire logic [7:0] tp_low,
  input wire logic [7:0] tp_high,
  input wire logic high_en,
  input wire logic last_page,
  // Selected word
  output logic [15:0] word
);

  logic [PG_BITS-1:0] page;

  // Page source: last page, high pointer, or page zero
  always_comb begin
    if (last_page) begin
      page = LAST_PAGE; // RULE17
    end else if (high_en) begin
      page = tp_high[PG_BITS-1:0]; // RULE16
    end else begin
      page = '0; // RULE16
    end
    word = pmem[{page, tp_low[PAGE_AW-1:0]}];
  end

endmodule : rss_table_rd

//--- pkg/rss_pkg.sv
// ==========================================================================
// Shared constants and types
// ==========================================================================
package rss_pkg;

  // Storage geometry
  localparam int DM_AW = 4;
  localparam int DM_DEPTH = 16;
  localparam int PM_AW = 5;
  localparam int PM_DEPTH = 32;
  localparam int PAGE_AW = 4;
  localparam int PG_BITS = PM_AW - PAGE_AW;

  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_WORK = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_TPTR = 8'h0C;
  localparam logic [7:0] OFF_TLATCH = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_DMEM = 8'h40;
  localparam logic [7:0] OFF_PMEM = 8'h80;
  localparam logic [7:0] DMEM_MASK = 8'hC0;
  localparam logic [7:0] PMEM_MASK = 8'h80;
  localparam int IDX_LSB = 2;

  // Field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_LSB = 5;
  localparam int CMD_MA_LSB = 8;
  localparam int CMD_IMM_LSB = 16;
  localparam int TP_LOW_LSB = 0;
  localparam int TP_HIGH_LSB = 8;
  localparam int TP_HEN_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SKIP_BIT = 1;

  // Byte constants
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [PG_BITS-1:0] LAST_PAGE = '1;

  // Operation codes
  typedef enum logic [4:0] {
    OP_ROTL_CARRY_TO_WORK = 5'h00,
    OP_ROTR_MEM = 5'h01,
    OP_ROTR_TO_WORK = 5'h02,
    OP_ROTR_THRU_CARRY_MEM = 5'h03,
    OP_ROTR_THRU_CARRY_TO_WORK = 5'h04,
    OP_MINUS_BORROW_WORK = 5'h05,
    OP_MINUS_BORROW_MEM = 5'h06,
    OP_SUBTRACT_WORK = 5'h07,
    OP_SUBTRACT_IMM = 5'h08,
    OP_SUBTRACT_TO_MEM = 5'h09,
    OP_DEC_SKIP_ZERO = 5'h0A,
    OP_DEC_SKIP_ZERO_WORK = 5'h0B,
    OP_INC_SKIP_ZERO = 5'h0C,
    OP_INC_SKIP_ZERO_WORK = 5'h0D,
    OP_SET_BYTE = 5'h0E,
    OP_SET_BIT = 5'h0F,
    OP_SKIP_BIT_SET = 5'h10,
    OP_SKIP_IF_ZERO = 5'h11,
    OP_COPY_SKIP_ZERO = 5'h12,
    OP_SKIP_BIT_CLEAR = 5'h13,
    OP_NIBBLE_EXCHANGE_MEM = 5'h14,
    OP_NIBBLE_EXCHANGE_WORK = 5'h15,
    OP_TABLE_FETCH = 5'h16,
    OP_TABLE_FETCH_LAST_PAGE = 5'h17,
    OP_XOR_WORK = 5'h18
  } rss_op_t;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } rss_flags_t;

  typedef struct packed {
    logic [7:0] imm;
    logic [DM_AW-1:0] maddr;
    logic [2:0] bit_sel;
    logic [4:0] op;
  } rss_cmd_t;

  typedef struct packed {
    logic [7:0] result;
    rss_flags_t flags;
    logic wr_mem;
    logic wr_work;
    logic wr_latch;
    logic skip;
  } rss_alu_out_t;

  // One-hot mask for a bit index
  function automatic logic [7:0] rss_bit_mask(input logic [2:0] idx);
    rss_bit_mask = ONE_BYTE << idx;
  endfunction : rss_bit_mask

endpackage : rss_pkg

//--- tb/rss_exec_sva.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the execution unit
// ==========================================================================
module rss_exec_sva import rss_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status
  input wire logic busy,
  input wire logic skip_taken
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Completed transfer and accepted command
  logic done;
  logic cmd_ok;
  assign done = psel && penable && pready;
  assign cmd_ok = done && pwrite && !pslverr && (paddr == OFF_CMD);

  // ==========================================================================
  // Bus handshake
  // ==========================================================================
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held beyond one cycle");
  AST_UNALIGNED: assert property (done && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned access not refused");
  // Setup and access both seen while busy, so the write must bounce
  AST_BUSY_REFUSE: assert property (psel && !penable && pwrite && busy
    ##1 done && busy |-> pslverr)
    else $error("write while busy not refused");

  // ==========================================================================
  // Command timing
  // ==========================================================================
  AST_CMD_STARTS: assert property (cmd_ok |=> busy)
    else $error("accepted command did not start");
  AST_SKIP_CLEARS: assert property (cmd_ok |=> !skip_taken)
    else $error("skip flag not cleared by command");
  AST_BUSY_SHAPE: assert property ($rose(busy) |=>
    (!busy && !skip_taken) or (busy && skip_taken ##1 !busy))
    else $error("busy length does not match skip");
  AST_BUSY_MAX: assert property (busy ##1 busy |=> !busy)
    else $error("busy longer than two cycles");
  AST_SKIP_HOLDS: assert property (skip_taken &&
    !(psel && pwrite && paddr == OFF_CMD) |=> skip_taken)
    else $error("skip flag dropped without command");
  // Idle status read must mirror the skip output
  AST_STAT_READ: assert property (done && !pwrite &&
    paddr == OFF_STAT && !busy && !$past(busy)
    |-> prdata[1:0] == {skip_taken, 1'b0})
    else $error("status read disagrees with outputs");
endmodule : rss_exec_sva

bind rss_exec rss_exec_sva rss_exec_sva_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .busy(busy), .skip_taken(skip_taken));

//--- tb/testbench.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench with a behavioural model
// ==========================================================================
module testbench import rss_pkg::*;;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, busy, skip_taken;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int num_errors = 0;
  int cmp_count = 0;
  // Model state
  logic [7:0] m_work = 8'h00;
  logic [7:0] m_tl = 8'h00;
  logic [3:0] m_fl = 4'h0;
  logic [16:0] m_tp;
  logic m_skip;
  logic [7:0] m_dm [16];
  logic [15:0] m_pm [32];

  // Clock
  always #12.5 pclk = ~pclk;

  rss_exec rss_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
    .skip_taken(skip_taken));

  // ==========================================================================
  // Checking and bus tasks
  // ==========================================================================
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Entered just after a rising edge; b2b keeps psel up for a following setup
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input bit b2b, output logic [31:0] q,
    output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Ready, data and error are all taken at the completing rising edge
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 50);
    if (n >= 50) num_errors++;
    q = prdata;
    e = pslverr;
    if (!b2b) begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, 1'b0, q, e);
    check(32'(e), 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    xfer(1'b0, a, 32'h0, 1'b0, q, e);
    check(32'(e), 32'h0);
  endtask : rd

  // ==========================================================================
  // Behavioural model of one command
  // ==========================================================================
  task automatic model(input int op, input int b, input int ma,
    input int imm);
    logic [7:0] m;
    logic [7:0] r;
    logic [15:0] w;
    logic c;
    int bin;
    int pg;
    m = m_dm[ma];
    c = m_fl[0];
    m_skip = 1'b0;
    case (op)
      0: begin
        m_work = {m[6:0], c};
        m_fl[0] = m[7];
      end
      1: m_dm[ma] = {m[0], m[7:1]};
      2: m_work = {m[0], m[7:1]};
      3, 4: begin
        r = {c, m[7:1]};
        m_fl[0] = m[0];
        if (op == 3) m_dm[ma] = r;
        else m_work = r;
      end
      5, 6, 7, 8, 9: begin
        if (op == 8) m = 8'(imm);
        bin = (op < 7) ? int'(!c) : 0;
        r = 8'(m_work - m - bin);
        m_fl[0] = (m_work >= m + bin);
        m_fl[1] = (m_work[3:0] >= m[3:0] + bin);
        m_fl[2] = (r == 8'h00);
        m_fl[3] = (m_work[7] != m[7]) && (r[7] != m_work[7]);
        if (op == 6 || op == 9) m_dm[ma] = r;
        else m_work = r;
      end
      10, 11, 12, 13: begin
        r = (op < 12) ? m - 8'h01 : m + 8'h01;
        m_skip = (r == 8'h00);
        if (op % 2 == 1) m_work = r;
        else m_dm[ma] = r;
      end
      14: m_dm[ma] = 8'hFF;
      15: m_dm[ma][b] = 1'b1;
      16: m_skip = m[b];
      17: m_skip = (m == 8'h00);
      18: begin
        m_work = m;
        m_skip = (m == 8'h00);
      end
      19: m_skip = !m[b];
      20: m_dm[ma] = {m[3:0], m[7:4]};
      21: m_work = {m[3:0], m[7:4]};
      22, 23: begin
        pg = (op == 23) ? 1 : (m_tp[16] ? int'(m_tp[8]) : 0);
        w = m_pm[pg * 16 + int'(m_tp[3:0])];
        m_dm[ma] = w[7:0];
        m_tl = w[15:8];
      end
      24: begin
        m_work = m_work ^ m;
        m_fl[2] = (m_work == 8'h00);
      end
      default: ;
    endcase
  endtask : model

  // Wait for the command to retire, then compare status, work, flags, latch and the addressed byte
  task automatic verify(input int ma);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      rd(OFF_STAT, q);
      n++;
    end while (q[0] && n < 20);
    check(q, {30'h0, m_skip, 1'b0});
    check(32'(busy), 32'h0);
    check(32'(skip_taken), 32'(m_skip));
    rd(OFF_WORK, q);
    check(q, {24'h0, m_work});
    rd(OFF_FLAGS, q);
    check(q, {28'h0, m_fl});
    rd(OFF_TLATCH, q);
    check(q, {24'h0, m_tl});
    rd(OFF_DMEM + 8'(ma * 4), q);
    check(q, {24'h0, m_dm[ma]});
  endtask : verify

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [31:0] q;
    logic e;
    int op, ma, b, imm, v;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'h303E));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_WORK, q);
    check(q, 32'h0);
    for (int k = 0; k < 32; k++) begin
      if (k < 16) m_dm[k] = 8'h00;
      m_pm[k] = 16'($urandom);
      wr(OFF_PMEM + 8'(k * 4), {16'h0, m_pm[k]});
    end
    // Every code, including spare ones, four times; only codes that are multiples of four get edge operands
    for (int i = 0; i < 128; i++) begin
      op = i % 32;
      ma = $urandom % 16;
      b = $urandom % 8;
      imm = $urandom % 256;
      v = (i % 4 == 0) ? (i / 4) % 3 - 1 : int'($urandom);
      m_dm[ma] = 8'(v);
      m_work = (i % 5 == 0) ? m_dm[ma] : 8'($urandom);
      m_fl = 4'($urandom);
      m_tp = 17'($urandom);
      wr(OFF_DMEM + 8'(ma * 4), {24'h0, m_dm[ma]});
      wr(OFF_WORK, {24'h0, m_work});
      wr(OFF_FLAGS, {28'h0, m_fl});
      wr(OFF_TPTR, {15'h0, m_tp});
      wr(OFF_CMD, 32'((imm << 16) | (ma << 8) | (b << 5) | op));
      model(op, b, ma, imm);
      verify(ma);
    end
    // Write landing in the dummy cycle of a taken skip is bounced
    m_dm[0] = 8'h00;
    wr(OFF_DMEM, 32'h0);
    xfer(1'b1, OFF_CMD, 32'h11, 1'b1, q, e);
    check(32'(e), 32'h0);
    model(17, 0, 0, 0);
    xfer(1'b1, OFF_WORK, 32'h5A, 1'b0, q, e);
    check(32'(e), 32'h1);
    verify(0);
    // Unmapped and unaligned places
    xfer(1'b0, 8'h18, 32'h0, 1'b0, q, e);
    check(32'(e), 32'h1);
    xfer(1'b0, 8'h42, 32'h0, 1'b0, q, e);
    check(32'(e), 32'h1);
    // Latch is read-only from the bus
    wr(OFF_TLATCH, 32'hAB);
    verify(0);
    tally_and_finish();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : testbench
